// [logic/ctrl_fsm.sv]
// controller state machine: requests status changes of the other two machines
`timescale 1ns/1ps
`default_nettype none
`include "hwt_defs.svh"
module ctrl_fsm (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic restart_i,
	input wire logic [`NUM_W-1:0] hw_number_i,
	input wire hwt_pkg::cmd_code_t command_i,
	input wire logic [`DATA_W-1:0] argument_i,
	input wire hwt_pkg::status_code_t status_i,
	input wire hwt_pkg::side_state_t side_i,
	input wire hwt_pkg::call_code_t call_code_i,
	input wire logic [`DATA_W-1:0] operand_a_i,
	input wire logic [`DATA_W-1:0] operand_b_i,
	output hwt_pkg::status_order_t status_order_o,
	output hwt_pkg::logic_order_t logic_order_o,
	output logic [`DATA_W-1:0] result_o,
	output logic [`DATA_W-1:0] return_value_o,
	output logic [`DATA_W-1:0] outgoing_o,
	output logic [`PROBE_W-1:0] probe_o
);
	typedef enum logic [3:0] {C_START, C_UNASSIGNED, C_ASSIGN_WAIT, C_ASSIGNED, C_RUN_WAIT,
		C_RUNNING, C_RETURN_WAIT, C_DONE_WAIT, C_DONE, C_BLOCK_WAIT, C_WAITING_LOCK_STATE} ctrl_state_t;

	ctrl_state_t state_reg, state_next;
	hwt_pkg::status_order_t sord_reg, sord_next;
	hwt_pkg::logic_order_t lord_reg, lord_next;
	logic [`DATA_W-1:0] result_reg, result_next, rv_reg, rv_next, out_reg, out_next;
	logic sys_done, side_done;

	// an order is complied with once the owner's register shows its target
	assign sys_done = (status_i == hwt_pkg::order_target(sord_reg));
	assign side_done = (side_i == `SIDE_RUN);

	always_comb begin
		state_next = state_reg;
		sord_next = sord_reg;
		lord_next = lord_reg;
		result_next = result_reg;
		rv_next = rv_reg;
		out_next = out_reg;
		case (state_reg)
			C_START: begin
				sord_next = `ORD_NONE;
				lord_next = `LORD_NONE;
				result_next = 32'h0;
				rv_next = 32'h0;
				state_next = C_UNASSIGNED;
			end
			C_UNASSIGNED: begin
				if (hw_number_i != 8'h0) begin
					sord_next = `ORD_ASSIGNED;
					state_next = C_ASSIGN_WAIT;
				end
			end
			C_ASSIGNED: begin
				if (command_i == `CMD_RUN) begin
					sord_next = `ORD_RUN;
					lord_next = `LORD_RUN;
					rv_next = argument_i;
					state_next = C_RUN_WAIT;
				end
			end
			C_RUN_WAIT: begin
				if (sys_done) begin
					sord_next = `ORD_NONE;
				end
				if (side_done) begin
					lord_next = `LORD_NONE;
				end
				if ((sys_done || sord_reg == `ORD_NONE) && (side_done || lord_reg == `LORD_NONE)) begin
					state_next = C_RUNNING;
				end
			end
			C_RUNNING: begin
				if (side_i == `SIDE_ACK) begin
					case (call_code_i)
						`CALL_EXIT, `CALL_EXIT_ERR: begin
							sord_next = (call_code_i == `CALL_EXIT) ? `ORD_FINISHED : `ORD_FAILED;
							result_next = operand_a_i;
							state_next = C_DONE_WAIT;
						end
						`CALL_LOCK: begin
							sord_next = `ORD_WAITING;
							state_next = C_BLOCK_WAIT;
						end
						default: begin
							if (call_code_i == `CALL_SELF) begin
								rv_next = 32'(hw_number_i);
							end
							if (call_code_i == `CALL_WRITE) begin
								out_next = operand_b_i;
							end
							lord_next = `LORD_RUN;
							state_next = C_RETURN_WAIT;
						end
					endcase
				end
			end
			C_RETURN_WAIT: begin
				if (side_done) begin
					lord_next = `LORD_NONE;
					state_next = C_RUNNING;
				end
			end
			C_ASSIGN_WAIT, C_DONE_WAIT, C_BLOCK_WAIT: begin
				if (sys_done) begin
					sord_next = `ORD_NONE;
					case (state_reg)
						C_ASSIGN_WAIT: state_next = C_ASSIGNED;
						C_BLOCK_WAIT: state_next = C_WAITING_LOCK_STATE;
						default: state_next = C_DONE;
					endcase
				end
			end
			C_WAITING_LOCK_STATE: begin
				// command reads neutral while waiting, so this is a fresh run
				if (command_i == `CMD_RUN) begin
					sord_next = `ORD_RUN;
					lord_next = `LORD_RUN;
					state_next = C_RUN_WAIT;
				end
			end
			C_DONE: state_next = C_DONE;
			default: state_next = C_START;
		endcase
		if (restart_i) begin
			state_next = C_START;
			sord_next = `ORD_NONE;
			lord_next = `LORD_NONE;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= C_START;
			sord_reg <= `ORD_NONE;
			lord_reg <= `LORD_NONE;
			result_reg <= 32'h0;
			rv_reg <= 32'h0;
			out_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			sord_reg <= sord_next;
			lord_reg <= lord_next;
			result_reg <= result_next;
			rv_reg <= rv_next;
			out_reg <= out_next;
		end
	end

	assign status_order_o = sord_reg;
	assign logic_order_o = lord_reg;
	assign result_o = result_reg;
	assign return_value_o = rv_reg;
	assign outgoing_o = out_reg;
	assign probe_o = 4'(state_reg);

	logic_order_held_a: assert property (@(posedge clock_i) disable iff (!rst_n_i || restart_i)
		(lord_reg == `LORD_RUN && !side_done) |=> lord_reg == `LORD_RUN)
		else $error("run order dropped before compliance");
	logic_order_cleared_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(lord_reg == `LORD_RUN && side_done) |=> lord_reg == `LORD_NONE)
		else $error("run order not returned to no request");
endmodule
`default_nettype wire

// [logic/hwt_coord.sv]
// system state machine, slave register map and reset sequencing of the thread interface
`timescale 1ns/1ps
`default_nettype none
`include "hwt_defs.svh"
// Function
// - system machine owns system registers, controller owns result
// - initialisation loads status with unassigned
// - controller requests status changes through order code
// - status order has six codes
// - order held until applied, then no request
// - reset command acknowledged, bus ended, then reset
// - reset restarts all machines and user logic
// - three read-only probe registers show machine states
// - fetched data write acknowledged like slave write
// - outgoing data read acknowledged like slave read
// - unmapped reads return zero, writes ignored
// - advance-once and pause commands do nothing
// - command reads neutral after reset
// - command neutral while waiting for lock
// - user machine owns call registers, controller return
// - user machine changes side state on ack/reset
// - logic order has two codes
// - run order held until complied, then cleared
// - reset enters start and side state reset
// - side state stays reset until run command
// - nonzero call code moves side state to ack
// - two cycles after run before new request
module hwt_coord (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic sel_i,
	input wire logic wr_i,
	input wire logic [`ADDR_W-1:0] addr_i,
	input wire logic [`DATA_W-1:0] wdata_i,
	output logic [`DATA_W-1:0] rdata_o,
	output logic ack_o,
	input wire hwt_pkg::call_code_t req_code_i,
	input wire logic [`DATA_W-1:0] req_a_i,
	input wire logic [`DATA_W-1:0] req_b_i,
	output hwt_pkg::side_state_t side_state_o,
	output hwt_pkg::call_code_t call_code_o,
	output logic [`DATA_W-1:0] operand_a_o,
	output logic [`DATA_W-1:0] operand_b_o,
	output logic [`DATA_W-1:0] return_value_o,
	output logic user_reset_o,
	output hwt_pkg::status_code_t status_o,
	output logic [`DATA_W-1:0] fetched_data_o
);
	typedef enum logic [3:0] {S_START, S_IDLE, S_RESET_ACK, S_RESET_WAIT, S_RUN_CHECK,
		S_END, S_END_WAIT} sys_state_t;

	sys_state_t sys_state_reg, sys_state_next;
	logic [`NUM_W-1:0] hw_number_reg, hw_number_next;
	hwt_pkg::status_code_t status_reg, status_next;
	hwt_pkg::cmd_code_t command_reg, command_next;
	logic [`DATA_W-1:0] argument_reg, argument_next;
	logic [`DATA_W-1:0] verify_reg, verify_next;
	logic [`DATA_W-1:0] fetched_reg, fetched_next;
	logic [`DATA_W-1:0] rdata_reg, rdata_next;
	logic soft_rst_reg, soft_rst_next;

	hwt_pkg::status_order_t status_order;
	hwt_pkg::logic_order_t logic_order;
	logic [`DATA_W-1:0] result_w;
	logic [`DATA_W-1:0] outgoing_w;
	logic [`PROBE_W-1:0] user_probe;
	logic [`PROBE_W-1:0] ctrl_probe;
	logic unmapped;

	user_fsm u_user (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.restart_i(soft_rst_reg),
		.order_i(logic_order),
		.req_code_i(req_code_i),
		.req_a_i(req_a_i),
		.req_b_i(req_b_i),
		.side_state_o(side_state_o),
		.call_code_o(call_code_o),
		.operand_a_o(operand_a_o),
		.operand_b_o(operand_b_o),
		.probe_o(user_probe),
		.user_reset_o(user_reset_o)
	);

	ctrl_fsm u_ctrl (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.restart_i(soft_rst_reg),
		.hw_number_i(hw_number_reg),
		.command_i(command_reg),
		.argument_i(argument_reg),
		.status_i(status_reg),
		.side_i(side_state_o),
		.call_code_i(call_code_o),
		.operand_a_i(operand_a_o),
		.operand_b_i(operand_b_o),
		.status_order_o(status_order),
		.logic_order_o(logic_order),
		.result_o(result_w),
		.return_value_o(return_value_o),
		.outgoing_o(outgoing_w),
		.probe_o(ctrl_probe)
	);

	always_comb begin
		case (addr_i)
			`REG_HW_NUMBER, `REG_COMMAND, `REG_STATUS, `REG_ARGUMENT, `REG_RESULT,
			`REG_VERIFY, `REG_SYS_PROBE, `REG_USER_PROBE, `REG_CTRL_PROBE,
			`REG_FETCHED, `REG_OUTGOING: unmapped = 1'b0;
			default: unmapped = 1'b1;
		endcase
	end

	always_comb begin
		sys_state_next = sys_state_reg;
		hw_number_next = hw_number_reg;
		status_next = status_reg;
		command_next = command_reg;
		argument_next = argument_reg;
		verify_next = verify_reg;
		fetched_next = fetched_reg;
		rdata_next = rdata_reg;
		soft_rst_next = 1'b0;
		case (sys_state_reg)
			S_START: begin
				hw_number_next = 8'h0;
				status_next = `STAT_UNASSIGNED;
				command_next = `CMD_NEUTRAL;
				argument_next = 32'h0;
				verify_next = 32'h0;
				sys_state_next = S_IDLE;
			end
			S_IDLE: begin
				if (status_order != `ORD_NONE) begin
					status_next = hwt_pkg::order_target(status_order);
					// a stale run must not wake the thread once it waits for a lock
					if (status_order == `ORD_WAITING) begin
						command_next = `CMD_NEUTRAL;
					end
				end
				if (sel_i) begin
					sys_state_next = S_END;
					if (wr_i) begin
						case (addr_i)
							`REG_HW_NUMBER: hw_number_next = wdata_i[`NUM_W-1:0];
							`REG_ARGUMENT: argument_next = wdata_i;
							`REG_VERIFY: verify_next = wdata_i;
							`REG_FETCHED: fetched_next = wdata_i;
							`REG_COMMAND: begin
								if (wdata_i[`CMD_W-1:0] == `CMD_RESET) begin
									sys_state_next = S_RESET_ACK;
								end else if (wdata_i[`CMD_W-1:0] == `CMD_RUN) begin
									sys_state_next = S_RUN_CHECK;
								end else if (status_next != `STAT_WAITING) begin
									// advance-once and pause are stored but steer nothing
									command_next = wdata_i[`CMD_W-1:0];
								end
							end
							default: ;
						endcase
					end else begin
						case (addr_i)
							`REG_HW_NUMBER: rdata_next = 32'(hw_number_reg);
							`REG_COMMAND: rdata_next = 32'(command_reg);
							`REG_STATUS: rdata_next = 32'(status_reg);
							`REG_ARGUMENT: rdata_next = argument_reg;
							`REG_RESULT: rdata_next = result_w;
							`REG_VERIFY: rdata_next = verify_reg;
							`REG_SYS_PROBE: rdata_next = 32'(sys_state_reg);
							`REG_USER_PROBE: rdata_next = 32'(user_probe);
							`REG_CTRL_PROBE: rdata_next = 32'(ctrl_probe);
							`REG_FETCHED: rdata_next = fetched_reg;
							`REG_OUTGOING: rdata_next = outgoing_w;
							default: rdata_next = 32'h0;
						endcase
					end
				end
			end
			S_RUN_CHECK: begin
				if (status_reg == `STAT_ASSIGNED || status_reg == `STAT_WAITING) begin
					command_next = `CMD_RUN;
				end
				sys_state_next = S_END;
			end
			S_RESET_ACK: sys_state_next = S_RESET_WAIT;
			S_RESET_WAIT: begin
				// reset only after the chip enable drops, or the bus cycle would be cut
				if (!sel_i) begin
					soft_rst_next = 1'b1;
					sys_state_next = S_START;
				end
			end
			S_END: sys_state_next = S_END_WAIT;
			S_END_WAIT: begin
				if (!sel_i) begin
					sys_state_next = S_IDLE;
				end
			end
			default: sys_state_next = S_START;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_state_reg <= S_START;
			hw_number_reg <= 8'h0;
			status_reg <= `STAT_UNASSIGNED;
			command_reg <= `CMD_NEUTRAL;
			argument_reg <= 32'h0;
			verify_reg <= 32'h0;
			fetched_reg <= 32'h0;
			rdata_reg <= 32'h0;
			soft_rst_reg <= 1'b0;
		end else begin
			sys_state_reg <= sys_state_next;
			hw_number_reg <= hw_number_next;
			status_reg <= status_next;
			command_reg <= command_next;
			argument_reg <= argument_next;
			verify_reg <= verify_next;
			fetched_reg <= fetched_next;
			rdata_reg <= rdata_next;
			soft_rst_reg <= soft_rst_next;
		end
	end

	assign ack_o = (sys_state_reg == S_END) || (sys_state_reg == S_RESET_ACK);
	assign rdata_o = rdata_reg;
	assign status_o = status_reg;
	assign fetched_data_o = fetched_reg;

	sequence reset_write_s;
		sys_state_reg == S_IDLE && sel_i && wr_i && addr_i == `REG_COMMAND
			&& wdata_i[`CMD_W-1:0] == `CMD_RESET;
	endsequence
	sequence reset_ack_s;
		ack_o && !soft_rst_reg;
	endsequence

	reset_after_bus_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		soft_rst_reg |-> $past(sys_state_reg) == S_RESET_WAIT && !$past(sel_i))
		else $error("internal reset started during bus cycle");
	reset_acked_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		reset_write_s |=> reset_ack_s)
		else $error("reset write not acknowledged first");
	reset_all_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		soft_rst_reg |-> sys_state_reg == S_START ##1 user_reset_o && ctrl_probe == 4'h0)
		else $error("machines not restarted together");
	init_unassigned_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		sys_state_reg == S_START |=> status_reg == `STAT_UNASSIGNED
			&& command_reg == `CMD_NEUTRAL)
		else $error("status or command not initialised");
	order_applied_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && status_order != `ORD_NONE)
		|=> status_reg == hwt_pkg::order_target($past(status_order)))
		else $error("status order not applied");
	order_held_a: assert property (@(posedge clock_i) disable iff (!rst_n_i || soft_rst_reg)
		(status_order != `ORD_NONE && status_reg != hwt_pkg::order_target(status_order))
		|=> status_order == $past(status_order))
		else $error("status order dropped early");
	waiting_neutral_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$rose(status_reg == `STAT_WAITING) |-> command_reg == `CMD_NEUTRAL)
		else $error("command not neutral while waiting");
	unmapped_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && !wr_i && unmapped) |=> ack_o && rdata_o == 32'h0)
		else $error("unmapped read not zero");
	never_reset_cmd_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		command_reg != `CMD_RESET)
		else $error("command reads reset");
	fetched_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && wr_i && addr_i == `REG_FETCHED)
		|=> ack_o && fetched_data_o == $past(wdata_i))
		else $error("fetched data write not taken");
	outgoing_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && !wr_i && addr_i == `REG_OUTGOING)
		|=> ack_o && rdata_o == $past(outgoing_w))
		else $error("outgoing data read wrong");
	probe_sys_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && !wr_i && addr_i == `REG_SYS_PROBE)
		|=> rdata_o == 32'(S_IDLE))
		else $error("system probe wrong");
	probe_user_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && !wr_i && addr_i == `REG_USER_PROBE)
		|=> rdata_o == 32'($past(user_probe)))
		else $error("user probe wrong");
	status_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && wr_i && addr_i == `REG_STATUS
			&& status_order == `ORD_NONE) |=> $stable(status_reg))
		else $error("bus write changed status");
	unmapped_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && wr_i && unmapped)
		|=> $stable(hw_number_reg) && $stable(argument_reg) && $stable(verify_reg)
			&& $stable(fetched_reg))
		else $error("unmapped write changed a register");
	step_ignored_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(sys_state_reg == S_IDLE && sel_i && wr_i && addr_i == `REG_COMMAND
			&& status_order == `ORD_NONE
			&& (wdata_i[`CMD_W-1:0] == `CMD_ADVANCE_ONCE || wdata_i[`CMD_W-1:0] == `CMD_PAUSE))
		|=> $stable(status_reg) && sys_state_reg == S_END)
		else $error("step or pause command acted");
	waiting_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(status_reg == `STAT_WAITING && command_reg == `CMD_NEUTRAL
			&& sys_state_reg != S_RUN_CHECK) |=> command_reg == `CMD_NEUTRAL)
		else $error("command left neutral while waiting");
endmodule
`default_nettype wire

// [logic/hwt_defs.svh]
// register indices, code values and widths for the thread status coordination block
`ifndef HWT_DEFS_SVH
`define HWT_DEFS_SVH

`define DATA_W 32
`define ADDR_W 4
`define NUM_W 8
`define STAT_W 3
`define CMD_W 4
`define SIDE_W 2
`define ORD_W 3
`define CALL_W 4
`define PROBE_W 4

// word indices of the slave registers
`define REG_HW_NUMBER 4'h0
`define REG_COMMAND 4'h1
`define REG_STATUS 4'h2
`define REG_ARGUMENT 4'h3
`define REG_RESULT 4'h4
`define REG_VERIFY 4'h5
`define REG_SYS_PROBE 4'h6
`define REG_USER_PROBE 4'h7
`define REG_CTRL_PROBE 4'h8
`define REG_FETCHED 4'h9
`define REG_OUTGOING 4'hA

// system status codes
`define STAT_UNASSIGNED 3'h0
`define STAT_ASSIGNED 3'h1
`define STAT_RUN 3'h2
`define STAT_FINISHED 3'h3
`define STAT_FAILED 3'h4
`define STAT_WAITING 3'h5

// command codes
`define CMD_NEUTRAL 4'h0
`define CMD_RESET 4'h1
`define CMD_RUN 4'h2
`define CMD_ADVANCE_ONCE 4'h3
`define CMD_PAUSE 4'h4

// logic side states
`define SIDE_RESET 2'h0
`define SIDE_RUN 2'h1
`define SIDE_ACK 2'h2

// status change orders
`define ORD_NONE 3'h0
`define ORD_ASSIGNED 3'h1
`define ORD_RUN 3'h2
`define ORD_FINISHED 3'h3
`define ORD_FAILED 3'h4
`define ORD_WAITING 3'h5

// logic status orders
`define LORD_NONE 1'h0
`define LORD_RUN 1'h1

// call codes from the thread user logic
`define CALL_NONE 4'h0
`define CALL_EXIT 4'h1
`define CALL_EXIT_ERR 4'h2
`define CALL_LOCK 4'h3
`define CALL_SELF 4'h4
`define CALL_YIELD 4'h5
`define CALL_WRITE 4'h6

`define HOLD_CYCLES 2

`endif

// [logic/hwt_pkg.sv]
// shared code types and the order decoding function
`include "hwt_defs.svh"
package hwt_pkg;
	typedef logic [`STAT_W-1:0] status_code_t;
	typedef logic [`CMD_W-1:0] cmd_code_t;
	typedef logic [`SIDE_W-1:0] side_state_t;
	typedef logic [`ORD_W-1:0] status_order_t;
	typedef logic logic_order_t;
	typedef logic [`CALL_W-1:0] call_code_t;

	function automatic status_code_t order_target(input status_order_t o);
		case (o)
			`ORD_ASSIGNED: return `STAT_ASSIGNED;
			`ORD_RUN: return `STAT_RUN;
			`ORD_FINISHED: return `STAT_FINISHED;
			`ORD_FAILED: return `STAT_FAILED;
			`ORD_WAITING: return `STAT_WAITING;
			default: return `STAT_UNASSIGNED;
		endcase
	endfunction
endpackage

// [logic/user_fsm.sv]
// user state machine: owns the logic side state and the call registers
`timescale 1ns/1ps
`default_nettype none
`include "hwt_defs.svh"
module user_fsm (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic restart_i,
	input wire hwt_pkg::logic_order_t order_i,
	input wire hwt_pkg::call_code_t req_code_i,
	input wire logic [`DATA_W-1:0] req_a_i,
	input wire logic [`DATA_W-1:0] req_b_i,
	output hwt_pkg::side_state_t side_state_o,
	output hwt_pkg::call_code_t call_code_o,
	output logic [`DATA_W-1:0] operand_a_o,
	output logic [`DATA_W-1:0] operand_b_o,
	output logic [`PROBE_W-1:0] probe_o,
	output logic user_reset_o
);
	typedef enum logic [2:0] {U_START, U_RESET, U_RUN, U_ACK, U_HOLD} user_state_t;

	user_state_t state_reg, state_next;
	hwt_pkg::side_state_t side_reg, side_next;
	hwt_pkg::call_code_t code_reg, code_next;
	logic [`DATA_W-1:0] a_reg, a_next, b_reg, b_next;
	logic [1:0] hold_reg, hold_next;

	always_comb begin
		state_next = state_reg;
		side_next = side_reg;
		code_next = code_reg;
		a_next = a_reg;
		b_next = b_reg;
		hold_next = hold_reg;
		case (state_reg)
			U_START: begin
				side_next = `SIDE_RESET;
				code_next = `CALL_NONE;
				state_next = U_RESET;
			end
			U_RESET: begin
				// only the controller's run order, after a fresh run command, leaves reset
				if (order_i == `LORD_RUN) begin
					side_next = `SIDE_RUN;
					hold_next = 2'(`HOLD_CYCLES);
					state_next = U_HOLD;
				end
			end
			U_RUN: begin
				if (req_code_i != `CALL_NONE) begin
					side_next = `SIDE_ACK;
					code_next = req_code_i;
					a_next = req_a_i;
					b_next = req_b_i;
					state_next = U_ACK;
				end
			end
			U_ACK: begin
				if (order_i == `LORD_RUN) begin
					side_next = `SIDE_RUN;
					hold_next = 2'(`HOLD_CYCLES);
					state_next = U_HOLD;
				end
			end
			U_HOLD: begin
				// settle time so the user logic sees run before a new request is taken
				if (hold_reg == 2'h1) begin
					state_next = U_RUN;
				end
				hold_next = hold_reg - 2'h1;
			end
			default: state_next = U_START;
		endcase
		if (restart_i) begin
			state_next = U_START;
			side_next = `SIDE_RESET;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= U_START;
			side_reg <= `SIDE_RESET;
			code_reg <= `CALL_NONE;
			a_reg <= 32'h0;
			b_reg <= 32'h0;
			hold_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			side_reg <= side_next;
			code_reg <= code_next;
			a_reg <= a_next;
			b_reg <= b_next;
			hold_reg <= hold_next;
		end
	end

	assign side_state_o = side_reg;
	assign call_code_o = code_reg;
	assign operand_a_o = a_reg;
	assign operand_b_o = b_reg;
	assign probe_o = 4'(state_reg);
	assign user_reset_o = (state_reg == U_START);

	reset_side_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		user_reset_o |=> side_state_o == `SIDE_RESET)
		else $error("logic side state not reset");
	reset_stays_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_reg == U_RESET && order_i == `LORD_NONE) |=> side_state_o == `SIDE_RESET)
		else $error("logic side left reset without run");
	request_ack_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_reg == U_RUN && req_code_i != `CALL_NONE && !restart_i)
		|=> side_state_o == `SIDE_ACK && call_code_o == $past(req_code_i))
		else $error("request not acknowledged");
	run_settle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i || restart_i)
		(state_reg == U_ACK && order_i == `LORD_RUN)
		|=> (side_state_o == `SIDE_RUN && state_reg != U_RUN)[*2] ##1 state_reg == U_RUN)
		else $error("two cycle wait after run broken");
endmodule
`default_nettype wire

// [verif/hwt_coord_bench.sv]
// self-checking bench: bus accesses, thread calls, status changes and soft reset
`timescale 1ns/1ps
`default_nettype none
`include "hwt_defs.svh"
module hwt_coord_bench;
	logic clock_i, rst_n_i, sel_i, wr_i, ack_o, user_reset_o;
	logic [3:0] addr_i;
	logic [31:0] wdata_i, rdata_o, op_a, op_b, ret_v, fetched, req_a, req_b, r;
	hwt_pkg::call_code_t req_code, call_code;
	hwt_pkg::side_state_t side;
	hwt_pkg::status_code_t status;
	logic [31:0] exp_q[$];
	int n_mismatch = 0;
	int check_count = 0;
	int n;
	hwt_coord hwt_coord_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .sel_i(sel_i), .wr_i(wr_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o),
		.req_code_i(req_code), .req_a_i(req_a), .req_b_i(req_b), .side_state_o(side),
		.call_code_o(call_code), .operand_a_o(op_a), .operand_b_o(op_b),
		.return_value_o(ret_v), .user_reset_o(user_reset_o), .status_o(status),
		.fetched_data_o(fetched));
	user_logic_model user_logic_model_inst (.clock_i(clock_i), .side_i(side),
		.code_o(req_code), .a_o(req_a), .b_o(req_b));
	initial begin
		clock_i = 0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// a read notes d as the expected word; the monitor below compares it
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		if (!w) exp_q.push_back(d);
		@(negedge clock_i);
		sel_i = 1;
		wr_i = w;
		addr_i = a;
		wdata_i = d;
		while (ack_o !== 1'b1 && k < 50) begin
			@(negedge clock_i);
			k++;
		end
		if (k == 50) begin
			n_mismatch++;
			results();
		end
		@(negedge clock_i);
		sel_i = 0;
	endtask
	task automatic wait_st(input hwt_pkg::status_code_t e);
		int k;
		k = 0;
		while (status !== e && k < 50) begin
			@(negedge clock_i);
			k++;
		end
		chk("status", 32'(e), 32'(status));
		if (k == 50) results();
	endtask
	// a call that times out or meets a reset counts as a mismatch and ends the run
	task automatic ucall(input hwt_pkg::call_code_t c, input logic [31:0] a,
		input logic [31:0] b);
		user_logic_model_inst.call(c, a, b, n);
		if (n >= 60) begin
			n_mismatch++;
			results();
		end
	endtask
	always @(negedge clock_i) begin
		if (ack_o === 1'b1 && wr_i === 1'b0) chk("rdata", exp_q.pop_front(), rdata_o);
	end
	initial begin
		void'($urandom(32'hFA5C2A0C));
		rst_n_i = 0;
		sel_i = 0;
		wr_i = 0;
		addr_i = 4'h0;
		wdata_i = 32'h0;
		repeat (6) @(negedge clock_i);
		rst_n_i = 1;
		repeat (2) @(negedge clock_i);
		chk("side", 32'(`SIDE_RESET), 32'(side));
		chk("status", 32'(`STAT_UNASSIGNED), 32'(status));
		bus(0, `REG_COMMAND, 32'(`CMD_NEUTRAL));
		$display("test reset values done");
		r = $urandom;
		bus(1, 4'hF, r);
		bus(0, 4'hF, 32'h0);
		bus(1, `REG_STATUS, r);
		bus(0, `REG_STATUS, 32'h0);
		bus(1, `REG_VERIFY, r);
		bus(0, `REG_VERIFY, r);
		$display("test unmapped done");
		bus(1, `REG_HW_NUMBER, 32'h5);
		bus(0, `REG_HW_NUMBER, 32'h5);
		wait_st(`STAT_ASSIGNED);
		bus(1, `REG_COMMAND, 32'(`CMD_ADVANCE_ONCE));
		bus(1, `REG_COMMAND, 32'(`CMD_PAUSE));
		bus(0, `REG_COMMAND, 32'(`CMD_PAUSE));
		chk("status", 32'(`STAT_ASSIGNED), 32'(status));
		chk("side", 32'(`SIDE_RESET), 32'(side));
		bus(1, `REG_ARGUMENT, ~r);
		bus(0, `REG_ARGUMENT, ~r);
		bus(1, `REG_COMMAND, 32'(`CMD_RUN));
		wait_st(`STAT_RUN);
		chk("return", ~r, ret_v);
		bus(1, `REG_FETCHED, r);
		chk("fetched", r, fetched);
		ucall(`CALL_YIELD, r, r);
		chk("ack wait", 32'h1, n);
		ucall(`CALL_SELF, r, r);
		chk("hold wait", 32'h3, n);
		ucall(`CALL_WRITE, r, ~r);
		chk("call code", 32'(`CALL_WRITE), 32'(call_code));
		chk("operand a", r, op_a);
		chk("operand b", ~r, op_b);
		chk("return", 32'h5, ret_v);
		bus(0, `REG_OUTGOING, ~r);
		$display("test calls done");
		ucall(`CALL_LOCK, r, r);
		wait_st(`STAT_WAITING);
		bus(1, `REG_COMMAND, 32'(`CMD_PAUSE));
		bus(0, `REG_COMMAND, 32'(`CMD_NEUTRAL));
		bus(1, `REG_COMMAND, 32'(`CMD_RUN));
		wait_st(`STAT_RUN);
		$display("test lock done");
		bus(1, `REG_COMMAND, 32'(`CMD_RESET));
		chk("user reset", 32'h0, 32'(user_reset_o));
		n = 0;
		while (user_reset_o !== 1'b1 && n < 10) begin
			@(negedge clock_i);
			n++;
		end
		chk("user reset", 32'h1, 32'(user_reset_o));
		chk("status", 32'(`STAT_UNASSIGNED), 32'(status));
		@(negedge clock_i);
		chk("side", 32'(`SIDE_RESET), 32'(side));
		bus(0, `REG_COMMAND, 32'(`CMD_NEUTRAL));
		bus(0, `REG_SYS_PROBE, 32'h1);
		bus(0, `REG_USER_PROBE, 32'h1);
		bus(0, `REG_CTRL_PROBE, 32'h1);
		$display("test soft reset done");
		bus(1, `REG_HW_NUMBER, 32'h5);
		wait_st(`STAT_ASSIGNED);
		bus(1, `REG_COMMAND, 32'(`CMD_RUN));
		wait_st(`STAT_RUN);
		ucall(`CALL_EXIT, r, r);
		wait_st(`STAT_FINISHED);
		bus(0, `REG_RESULT, r);
		$display("test exit done");
		results();
	end
endmodule
`default_nettype wire

// [verif/user_logic_model.sv]
// thread user logic model: raises calls and drops them once acknowledged
`timescale 1ns/1ps
`default_nettype none
`include "hwt_defs.svh"
module user_logic_model (
	input wire logic clock_i,
	input wire hwt_pkg::side_state_t side_i,
	output var hwt_pkg::call_code_t code_o,
	output var logic [31:0] a_o,
	output var logic [31:0] b_o
);
	initial begin
		code_o = `CALL_NONE;
		a_o = 32'h0;
		b_o = 32'h0;
	end
	// operands toggle outside a call so a stale value is never taken for a fresh one
	always @(posedge clock_i) begin
		if (code_o == `CALL_NONE) begin
			a_o <= ~a_o;
			b_o <= ~b_o;
		end
	end
	// n counts falling edges from raising the call until the acknowledge is seen
	task automatic call(input hwt_pkg::call_code_t c, input logic [31:0] a, input logic [31:0] b,
		output int n);
		int w;
		w = 0;
		n = 0;
		while (side_i !== `SIDE_RUN && w < 60) begin
			@(negedge clock_i);
			w++;
		end
		// a side that never returns to run marks the call as failed
		if (w == 60) n = 60;
		code_o = c;
		a_o = a;
		b_o = b;
		while (side_i !== `SIDE_ACK && n < 60) begin
			@(negedge clock_i);
			n++;
			if (side_i === `SIDE_RESET) n = 60;
		end
		code_o = `CALL_NONE;
	endtask
endmodule
`default_nettype wire
